// [mac_pkg.sv]
// Constants, field layouts and carrier types for the 16x16 multiply accumulator.
// Assumes a single pclk domain and an APB register window decoded on 12 address bits.
package mac_pkg;

    // ------------------------------------------------------------------
    // Datapath widths and field positions
    // ------------------------------------------------------------------
    localparam int OPW       = 16;
    localparam int RESW      = 35;
    localparam int EXTW      = 3;
    localparam int EXT_LSB   = 32;
    localparam int UPPER_LSB = 16;
    localparam int LOWER_LSB = 0;

    // Rounding adds a one at product bit 15
    localparam logic [34:0] ROUND_ADD = 35'h000008000;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [34:0] RESULT_RESET  = 35'h000000000;
    localparam logic [15:0] OPERAND_RESET = 16'h0000;
    localparam logic        FREEZE_RESET  = 1'b0;

    // ------------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          AW            = 12;
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_RESULT_LO = 12'h004;
    localparam logic [11:0] OFS_RESULT_HI = 12'h008;
    localparam logic [11:0] OFS_OPERANDS  = 12'h00c;
    localparam logic [11:0] OFS_STATUS    = 12'h010;
    localparam int          CTRL_FREEZE_BIT = 0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic subtract_select;
        logic accumulate_select;
        logic round_select;
        logic signed_select;
    } op_ctrl_t;

    typedef struct packed {
        logic extended_field_enable;
        logic upper_field_enable;
        logic lower_field_enable;
    } field_en_t;

    typedef struct packed {
        logic [2:0]  extended_field;
        logic [15:0] upper_field;
        logic [15:0] lower_field;
    } result_port_t;

endpackage

// [multiply_accumulator_16x16.sv]
// 16x16 multiplier with a 35-bit accumulator/output register and three-state result ports.
// Assumes operand and result clocks arrive as pins synchronous to pclk; an APB master
// sits on the register side and the wire resolution of the ports is done outside.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module multiply_accumulator_16x16 (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [11:0]          paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 x_operand_clock,
    input  wire logic                 y_operand_clock,
    input  wire logic                 result_clock,
    input  wire logic [15:0]          x_operand,
    input  wire mac_pkg::op_ctrl_t    op_ctrl,
    input  wire logic                 preload_select,
    input  wire mac_pkg::field_en_t   field_enable,
    input  wire mac_pkg::result_port_t port_in,
    output mac_pkg::result_port_t     port_out,
    output mac_pkg::field_en_t        port_oe
);

    // ------------------------------------------------------------------
    // Clock edge detection
    // ------------------------------------------------------------------
    logic xclk_q;
    logic yclk_q;
    logic rclk_q;
    logic x_rise;
    logic y_rise;
    logic r_rise;

    // Pins are synchronous, so the previous sample alone finds each rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xclk_q <= 1'b0;
            yclk_q <= 1'b0;
            rclk_q <= 1'b0;
        end else begin
            xclk_q <= x_operand_clock;
            yclk_q <= y_operand_clock;
            rclk_q <= result_clock;
        end
    end

    assign x_rise = x_operand_clock & ~xclk_q;
    assign y_rise = y_operand_clock & ~yclk_q;
    assign r_rise = result_clock & ~rclk_q;

    // ------------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------------
    logic [15:0]       x_q;
    logic [15:0]       x_d;
    logic [15:0]       y_q;
    logic [15:0]       y_d;
    mac_pkg::op_ctrl_t ctrl_q;
    mac_pkg::op_ctrl_t ctrl_d;

    // Operands and controls hold until their own clock edge
    always_comb begin
        x_d    = x_q;
        y_d    = y_q;
        ctrl_d = ctrl_q;
        if (x_rise) begin
            x_d = x_operand;
        end
        if (y_rise) begin
            y_d = port_in.lower_field;
        end
        if (x_rise | y_rise) begin
            ctrl_d = op_ctrl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_q    <= mac_pkg::OPERAND_RESET;
            y_q    <= mac_pkg::OPERAND_RESET;
            ctrl_q <= '0;
        end else begin
            x_q    <= x_d;
            y_q    <= y_d;
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------
    // Multiplier and rounding
    // ------------------------------------------------------------------
    logic signed [16:0] x_ext;
    logic signed [16:0] y_ext;
    logic signed [33:0] prod_wide;
    logic        [34:0] prod_ext;
    logic        [34:0] rounded;

    // A 17-bit signed multiply covers both modes: unsigned operands get a zero top bit
    always_comb begin
        x_ext     = $signed({ctrl_q.signed_select & x_q[15], x_q});
        y_ext     = $signed({ctrl_q.signed_select & y_q[15], y_q});
        prod_wide = x_ext * y_ext;
        prod_ext  = {prod_wide[33], prod_wide};
        rounded   = prod_ext;
        if (ctrl_q.round_select) begin
            rounded = prod_ext + mac_pkg::ROUND_ADD;
        end
    end

    // ------------------------------------------------------------------
    // Accumulator / output register
    // ------------------------------------------------------------------
    logic [34:0] result_q;
    logic [34:0] result_d;
    logic        freeze_q;
    logic        freeze_d;
    logic        result_load;
    logic [34:0] pin_word;

    // Software freeze lets a debugger inspect a stable result while pins keep toggling
    assign result_load = r_rise & ~freeze_q;
    assign pin_word    = port_in;

    always_comb begin
        result_d = result_q;
        if (result_load) begin
            if (preload_select) begin
                // Arithmetic controls play no part here
                if (field_enable.extended_field_enable) begin
                    result_d[34:32] = pin_word[34:32];
                end
                if (field_enable.upper_field_enable) begin
                    result_d[31:16] = pin_word[31:16];
                end
                if (field_enable.lower_field_enable) begin
                    result_d[15:0] = pin_word[15:0];
                end
            end else if (!ctrl_q.accumulate_select) begin
                result_d = rounded;
            end else if (ctrl_q.subtract_select) begin
                result_d = rounded - result_q;
            end else begin
                result_d = rounded + result_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= mac_pkg::RESULT_RESET;
        end else begin
            result_q <= result_d;
        end
    end

    // ------------------------------------------------------------------
    // Result ports
    // ------------------------------------------------------------------
    // Data comes straight from the register; only the enables are decoded
    assign port_out = result_q;
    assign port_oe.extended_field_enable = ~preload_select
                                         & ~field_enable.extended_field_enable;
    assign port_oe.upper_field_enable    = ~preload_select
                                         & ~field_enable.upper_field_enable;
    assign port_oe.lower_field_enable    = ~preload_select
                                         & ~field_enable.lower_field_enable;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        mapped;
    logic [31:0] rd_word;

    // Decode and read mux; read-only registers ignore writes without error
    always_comb begin
        mapped  = 1'b1;
        rd_word = 32'h00000000;
        unique case (paddr)
            mac_pkg::OFS_CTRL:      rd_word = {31'h00000000, freeze_q};
            mac_pkg::OFS_RESULT_LO: rd_word = result_q[31:0];
            mac_pkg::OFS_RESULT_HI: rd_word = {29'h00000000, result_q[34:32]};
            mac_pkg::OFS_OPERANDS:  rd_word = {y_q, x_q};
            mac_pkg::OFS_STATUS:    rd_word = {27'h0000000, preload_select, ctrl_q};
            default:                mapped  = 1'b0;
        endcase
    end

    // Read data is latched in the setup cycle so it leaves a flip-flop in the access cycle
    always_comb begin
        prdata_d = prdata_q;
        freeze_d = freeze_q;
        if (psel & ~penable) begin
            prdata_d = pwrite ? 32'h00000000 : rd_word;
        end
        if (psel & penable & pwrite & (paddr == mac_pkg::OFS_CTRL)) begin
            freeze_d = pwdata[mac_pkg::CTRL_FREEZE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            freeze_q <= mac_pkg::FREEZE_RESET;
        end else begin
            prdata_q <= prdata_d;
            freeze_q <= freeze_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Math checks use fixed operands so the expected words are plain constants
    AST_X_CAPTURE: assert property (x_rise |=> x_q == $past(x_operand))
        else $error("X operand not captured on X clock rise");
    AST_Y_CAPTURE: assert property (y_rise |=> y_q == $past(port_in.lower_field))
        else $error("Y operand not captured from lower port");
    AST_CTRL_CAPTURE: assert property ((x_rise || y_rise) |=> ctrl_q == $past(op_ctrl))
        else $error("Controls not captured on operand clock");
    AST_SIGNED_MATH: assert property (
        ctrl_q.signed_select && !ctrl_q.round_select && x_q == 16'hffff && y_q == 16'h0001
        |-> rounded == 35'h7ffffffff)
        else $error("Signed product not sign extended");
    AST_UNSIGNED_MATH: assert property (
        !ctrl_q.signed_select && ctrl_q.round_select && x_q == 16'hffff && y_q == 16'hffff
        |-> rounded == 35'h0fffe8001)
        else $error("Unsigned rounded product wrong");
    AST_RESULT_STABLE: assert property (!result_load |=> $stable(result_q))
        else $error("Result changed without result clock");
    AST_LOAD_PRODUCT: assert property (
        result_load && !preload_select && !ctrl_q.accumulate_select
        |=> result_q == $past(rounded))
        else $error("Product not loaded");
    AST_ADD: assert property (
        result_load && !preload_select && ctrl_q.accumulate_select && !ctrl_q.subtract_select
        |=> result_q == 35'($past(rounded) + $past(result_q)))
        else $error("Accumulate add wrong");
    AST_SUBTRACT: assert property (
        result_load && !preload_select && ctrl_q.accumulate_select && ctrl_q.subtract_select
        |=> result_q == 35'($past(rounded) - $past(result_q)))
        else $error("Accumulate subtract wrong");
    AST_PRELOAD_UPPER: assert property (
        result_load && preload_select && field_enable.upper_field_enable
        |=> result_q[31:16] == $past(port_in.upper_field))
        else $error("Upper field not preloaded");
    AST_PRELOAD_EXT: assert property (
        result_load && preload_select && field_enable.extended_field_enable
        |=> result_q[34:32] == $past(port_in.extended_field))
        else $error("Extended field not preloaded");
    AST_PRELOAD_LOWER: assert property (
        result_load && preload_select && field_enable.lower_field_enable
        |=> result_q[15:0] == $past(port_in.lower_field))
        else $error("Lower field not preloaded");
    AST_PRELOAD_KEEP: assert property (
        result_load && preload_select && !field_enable.extended_field_enable
        |=> result_q[34:32] == $past(result_q[34:32]))
        else $error("Disabled field changed in preload");
    AST_PRELOAD_FLOAT: assert property (preload_select |-> port_oe == 3'b000)
        else $error("Port driven during preload");
    AST_OUTPUT_ENABLE: assert property (
        !preload_select && !field_enable.lower_field_enable
        |-> port_oe.lower_field_enable && port_out.lower_field == result_q[15:0])
        else $error("Lower port not driven when enabled");
    AST_OUTPUT_FLOAT: assert property (
        !preload_select && field_enable.upper_field_enable |-> !port_oe.upper_field_enable)
        else $error("Upper port driven while disabled");
    AST_EXT_DRIVE: assert property (
        !preload_select && !field_enable.extended_field_enable
        |-> port_oe.extended_field_enable && port_out.extended_field == result_q[34:32])
        else $error("Extended port not driven when enabled");

endmodule

`default_nettype wire

// [mac_host.sv]
// Far-side model: the datapath that feeds operands, controls and pin clocks.
// Assumes pclk from the bench; it resolves the three-state result ports itself.
`timescale 1ns/100ps
`default_nettype none

module mac_host (
    input  wire logic                   pclk,
    input  wire mac_pkg::result_port_t  port_out,
    input  wire mac_pkg::field_en_t     port_oe,
    output var logic                    x_operand_clock,
    output var logic                    y_operand_clock,
    output var logic                    result_clock,
    output var logic [15:0]             x_operand,
    output var mac_pkg::op_ctrl_t       op_ctrl,
    output var logic                    preload_select,
    output var mac_pkg::field_en_t      field_enable,
    output var mac_pkg::result_port_t   port_in
);
    mac_pkg::result_port_t drv_data;
    logic [2:0]            drv_en;
    logic                  flt;

    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    // A floating field toggles every cycle, so a stale value never passes
    initial flt = 1'b0;
    always @(posedge pclk) flt <= ~flt;

    // Device wins where it drives; otherwise the host data or the float pattern
    always_comb begin
        port_in.extended_field = port_oe[2] ? port_out.extended_field
                               : drv_en[2] ? drv_data.extended_field : {3{flt}};
        port_in.upper_field = port_oe[1] ? port_out.upper_field
                            : drv_en[1] ? drv_data.upper_field : {16{flt}};
        port_in.lower_field = port_oe[0] ? port_out.lower_field
                            : drv_en[0] ? drv_data.lower_field : {16{flt}};
    end

    // Quiet pins at time zero
    initial begin
        {x_operand_clock, y_operand_clock, result_clock, preload_select} = 4'h0;
        x_operand = 16'h0000;
        op_ctrl = '0;
        field_enable = '0;
        drv_data = '0;
        drv_en = 3'h0;
    end

    // Set mode pins and let one edge pass so the ports settle
    task automatic set_pins(input logic pre, input logic [2:0] en);
        @(posedge pclk);
        preload_select <= pre;
        field_enable <= en;
        @(posedge pclk);
    endtask

    // Operand pulse on both clocks, then an optional result edge
    task automatic op(input logic [15:0] x, input logic [15:0] y,
                      input mac_pkg::op_ctrl_t c, input logic rp);
        @(posedge pclk);
        x_operand <= x;
        op_ctrl <= c;
        drv_data.lower_field <= y;
        drv_en <= 3'h1;
        field_enable <= 3'h1;
        x_operand_clock <= 1'b1;
        y_operand_clock <= 1'b1;
        @(posedge pclk);
        x_operand_clock <= 1'b0;
        y_operand_clock <= 1'b0;
        drv_en <= 3'h0;
        field_enable <= 3'h0;
        @(posedge pclk);
        result_clock <= rp;
        @(posedge pclk);
        result_clock <= 1'b0;
        @(posedge pclk);
    endtask

    // Preload: data stays on the enabled fields across the result edge
    task automatic preload(input logic [2:0] en, input mac_pkg::result_port_t d);
        @(posedge pclk);
        preload_select <= 1'b1;
        field_enable <= en;
        drv_data <= d;
        drv_en <= en;
        result_clock <= 1'b1;
        @(posedge pclk);
        result_clock <= 1'b0;
        preload_select <= 1'b0;
        field_enable <= 3'h0;
        drv_en <= 3'h0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// [multiply_accumulator_16x16_bench.sv]
// Self-checking bench for the multiply accumulator with an APB master.
// Assumes mac_host drives every pin input; the bench owns APB only.
`timescale 1ns/100ps
`default_nettype none

module multiply_accumulator_16x16_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic xclk, yclk, rclk, pre, err;
    logic [15:0] xop, x, y;
    logic [34:0] exp;
    mac_pkg::op_ctrl_t ctl, c;
    mac_pkg::field_en_t fen, port_oe;
    mac_pkg::result_port_t pin, port_out, pd;
    int bad_count, comparisons;
    integer seed;

    multiply_accumulator_16x16 i_multiply_accumulator_16x16 (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .x_operand_clock(xclk), .y_operand_clock(yclk),
        .result_clock(rclk), .x_operand(xop), .op_ctrl(ctl), .preload_select(pre),
        .field_enable(fen), .port_in(pin), .port_out(port_out), .port_oe(port_oe));
    mac_host i_mac_host (
        .pclk(pclk), .port_out(port_out), .port_oe(port_oe), .x_operand_clock(xclk),
        .y_operand_clock(yclk), .result_clock(rclk), .x_operand(xop), .op_ctrl(ctl),
        .preload_select(pre), .field_enable(fen), .port_in(pin));

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Checking and bus helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [34:0] e, input logic [34:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(what, {3'h0, e}, {3'h0, rd});
    endtask

    // Sign-extend or zero-fill before the multiply; the sum wraps at 35 bits
    function automatic logic [34:0] calc(input logic [15:0] a, input logic [15:0] b,
                                         input mac_pkg::op_ctrl_t k, input logic [34:0] o);
        logic [34:0] p;
        p = {{19{k.signed_select & a[15]}}, a} * {{19{k.signed_select & b[15]}}, b};
        if (k.round_select) p = p + mac_pkg::ROUND_ADD;
        if (k.accumulate_select) p = k.subtract_select ? p - o : p + o;
        return p;
    endfunction

    task automatic summarize();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        summarize();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'hf0a2d8d8;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", mac_pkg::OFS_CTRL, 32'h0);
        rdchk("result_lo", mac_pkg::OFS_RESULT_LO, 32'h0);
        exp = '0;
        // Every control code, boundary operands first, then random ones
        for (int i = 0; i < 48; i++) begin
            x = (i < 8) ? (i[2] ? 16'h8000 : 16'hffff) : 16'($random(seed));
            y = (i < 8) ? (i[0] ? 16'h0001 : x) : 16'($random(seed));
            c = mac_pkg::op_ctrl_t'(i[3:0]);
            i_mac_host.op(x, y, c, 1'b1);
            exp = calc(x, y, c, exp);
            chk("port_out", exp, port_out);
            rdchk("result_lo", mac_pkg::OFS_RESULT_LO, exp[31:0]);
            rdchk("result_hi", mac_pkg::OFS_RESULT_HI, {29'h0, exp[34:32]});
            rdchk("operands", mac_pkg::OFS_OPERANDS, {y, x});
            rdchk("status", mac_pkg::OFS_STATUS, {28'h0, c});
        end
        // Operand edges alone leave the result alone
        i_mac_host.op(16'h1234, 16'h00a5, '0, 1'b0);
        chk("no result edge", exp, port_out);
        rdchk("operands", mac_pkg::OFS_OPERANDS, 32'h00a51234);
        // Freeze ignores result edges; read-only write and unmapped place refused
        apb(1'b1, mac_pkg::OFS_CTRL, 32'h1);
        rdchk("ctrl", mac_pkg::OFS_CTRL, 32'h1);
        i_mac_host.op(16'h0003, 16'h0005, c, 1'b1);
        chk("frozen", exp, port_out);
        apb(1'b1, mac_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, mac_pkg::OFS_RESULT_LO, 32'h5a5a5a5a);
        rdchk("result_lo", mac_pkg::OFS_RESULT_LO, exp[31:0]);
        apb(1'b0, 12'h014, 32'h0);
        chk("pslverr", 35'h1, {34'h0, err});
        chk("unmapped data", 35'h0, {3'h0, rd});
        // Output enables in both modes
        for (int p = 0; p < 2; p++)
            for (int f = 0; f < 8; f++) begin
                i_mac_host.set_pins(p[0], f[2:0]);
                chk("port_oe", {32'h0, p[0] ? 3'h0 : ~f[2:0]}, 35'(port_oe));
            end
        rdchk("status", mac_pkg::OFS_STATUS, {27'h0, 1'b1, c});
        i_mac_host.set_pins(1'b0, 3'h0);
        // Preload every enable pattern while subtract-accumulate stays registered
        for (int f = 0; f < 8; f++) begin
            pd = {3'($random(seed)), 16'($random(seed)), 16'($random(seed))};
            i_mac_host.preload(f[2:0], pd);
            if (f[2]) exp[34:32] = pd.extended_field;
            if (f[1]) exp[31:16] = pd.upper_field;
            if (f[0]) exp[15:0] = pd.lower_field;
            chk("preload", exp, port_out);
        end
        summarize();
    end
endmodule
`default_nettype wire
